// file: hw/usb_bus_event_flags.sv
// Bus event flags, frame counters and interrupt of a USB high-speed device.
`timescale 1ns/100ps
module usb_bus_event_flags
  import usb_event_pkg::*;
#(
  parameter int SLEEP_CYCLES = SLEEP_IDLE_CYCLES
)
(
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [DATA_W-1:0] rdata,
  output logic irq,
  input wire logic high_speed,
  input wire logic line_idle_j,
  input wire logic line_non_idle,
  input wire logic upstream_resume_drive,
  input wire logic resume_end_det,
  input wire logic bus_reset_end_det,
  input wire logic frame_start_det,
  input wire logic [FRAME_W-1:0] frame_start_number,
  input wire logic microframe_start_det
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations.

  logic [NUM_FLAGS-1:0] flags;
  logic [NUM_FLAGS-1:0] event_mask_register;
  logic controller_clock_freeze;
  logic [FRAME_W-1:0] frame_number;
  logic [MICRO_W-1:0] microframe_number;
  logic [NUM_FLAGS-1:0] set_event;
  logic [NUM_FLAGS-1:0] clear_request;
  logic [NUM_FLAGS-1:0] next_flags;
  logic write_clear;
  logic write_mask;
  logic write_control;
  logic [DATA_W-1:0] next_rdata;
  link_state_e link_state;
  link_state_e next_link_state;
  logic [IDLE_CNT_W-1:0] idle_count;
  logic sleep_reached;
  logic activity_filtered;
  logic activity_seen;
  logic revive_event;
  logic running;

  ////////////////////////////////////////////////////////////////////////////
  // Register write decode.

  // Only full addresses match; writes to any other offset are dropped.
  assign write_clear = wr && (addr == OFF_CLEAR);
  assign write_mask = wr && (addr == OFF_MASK);
  assign write_control = wr && (addr == OFF_CONTROL);

  // The controller logic runs only when its clock is not frozen.
  assign running = !controller_clock_freeze;

  // Mask register: a one lets the matching flag drive the interrupt.
  always_ff @(posedge clock) begin
    if (rst) begin
      event_mask_register <= MASK_RESET;
    end else if (ce && write_mask) begin
      event_mask_register <= wdata[NUM_FLAGS-1:0];
    end
  end

  // Control register: holds the clock-freeze bit.
  always_ff @(posedge clock) begin
    if (rst) begin
      controller_clock_freeze <= FREEZE_RESET;
    end else if (ce && write_control) begin
      controller_clock_freeze <= wdata[BIT_FREEZE];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Line activity filter and revive detection.

  line_activity_filter u_filter (
    .clock(clock),
    .rst(rst),
    .ce(ce),
    .raw_active(line_non_idle && !upstream_resume_drive),
    .filtered_active(activity_filtered)
  );

  // Remember the filtered level so a revive is one event per burst.
  always_ff @(posedge clock) begin
    if (rst) begin
      activity_seen <= 1'b0;
    end else if (ce) begin
      activity_seen <= activity_filtered;
    end
  end

  // Revive only from sleep; this path ignores the freeze bit on purpose,
  // because a frozen, sleeping controller depends on it to wake up.
  assign revive_event = activity_filtered && !activity_seen &&
                        (link_state == LINK_ASLEEP);

  ////////////////////////////////////////////////////////////////////////////
  // Idle tracking for the sleep flag.

  // Next state of the idle tracker.
  always_comb begin
    next_link_state = link_state;
    case (link_state)
      LINK_ACTIVE: begin
        if (running && line_idle_j) begin
          next_link_state = LINK_IDLE_COUNT;
        end
      end
      LINK_IDLE_COUNT: begin
        if (!line_idle_j) begin
          next_link_state = LINK_ACTIVE;
        end else if (sleep_reached) begin
          next_link_state = LINK_ASLEEP;
        end
      end
      LINK_ASLEEP: begin
        if (revive_event) begin
          next_link_state = LINK_ACTIVE;
        end
      end
      default: begin
        next_link_state = LINK_ACTIVE;
      end
    endcase
  end

  // State register of the idle tracker.
  always_ff @(posedge clock) begin
    if (rst) begin
      link_state <= LINK_ACTIVE;
    end else if (ce) begin
      link_state <= next_link_state;
    end
  end

  // Counts idle cycles; the count pauses while the clock is frozen.
  always_ff @(posedge clock) begin
    if (rst) begin
      idle_count <= '0;
    end else if (ce) begin
      if (link_state != LINK_IDLE_COUNT || !line_idle_j) begin
        idle_count <= '0;
      end else if (running && !sleep_reached) begin
        idle_count <= idle_count + 1'b1;
      end
    end
  end

  // The first idle cycle is the entry to counting, hence the minus two.
  assign sleep_reached = running &&
                         (idle_count == IDLE_CNT_W'(SLEEP_CYCLES - 2));

  ////////////////////////////////////////////////////////////////////////////
  // Flag set and clear terms.

  // Events that set flags; all but revive are held off by the freeze bit.
  always_comb begin
    set_event = '0;
    set_event[BIT_RESUME_END] = running && resume_end_det;
    set_event[BIT_REVIVE] = revive_event;
    set_event[BIT_RESET_END] = running && bus_reset_end_det;
    set_event[BIT_FRAME] = running && frame_start_det;
    set_event[BIT_MICROFRAME] = running && high_speed && microframe_start_det;
    set_event[BIT_SLEEP] = running && (link_state == LINK_IDLE_COUNT) &&
                           line_idle_j && sleep_reached;
  end

  // Clear requests: written ones, plus the cross-clear between sleep and revive.
  // A revive clear written while frozen is dropped, since the flag's clock is off.
  always_comb begin
    clear_request = write_clear ? wdata[NUM_FLAGS-1:0] : '0;
    clear_request[BIT_REVIVE] = (write_clear && wdata[BIT_REVIVE] && running) ||
                                set_event[BIT_SLEEP];
    clear_request[BIT_SLEEP] = (write_clear && wdata[BIT_SLEEP]) ||
                               set_event[BIT_REVIVE];
  end

  // Per-flag update; a set in the same cycle as a clear wins.
  genvar g;
  generate
    for (g = 0; g < NUM_FLAGS; g++) begin : g_flag
      assign next_flags[g] = set_event[g] | (flags[g] & ~clear_request[g]);
    end
  endgenerate

  // Flags are only written here, so software cannot set them.
  always_ff @(posedge clock) begin
    if (rst) begin
      flags <= FLAGS_RESET;
    end else if (ce) begin
      flags <= next_flags;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame and micro-frame numbers.

  // Frame number loads from each frame-start token while the clock is not frozen.
  always_ff @(posedge clock) begin
    if (rst) begin
      frame_number <= '0;
    end else if (ce && running && frame_start_det) begin
      frame_number <= frame_start_number;
    end
  end

  // In high-speed mode only and while not frozen, micro-frame restarts at each frame, else steps at each micro-frame token.
  always_ff @(posedge clock) begin
    if (rst) begin
      microframe_number <= '0;
    end else if (ce && running && high_speed) begin
      if (frame_start_det) begin
        microframe_number <= '0;
      end else if (microframe_start_det) begin
        microframe_number <= microframe_number + 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt output.

  // Registered from the next flag and mask values, so the line follows both with no lag.
  // A mask write therefore takes effect on the interrupt at the same edge as on the register.
  always_ff @(posedge clock) begin
    if (rst) begin
      irq <= 1'b0;
    end else if (ce) begin
      irq <= |(next_flags & (write_mask ? wdata[NUM_FLAGS-1:0] : event_mask_register));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register read path.

  // Read mux; the clear register and unmapped offsets read as zero.
  always_comb begin
    next_rdata = '0;
    if (rd) begin
      case (addr)
        OFF_STATUS: begin
          next_rdata[NUM_FLAGS-1:0] = flags;
        end
        OFF_FRAME: begin
          next_rdata[MICRO_W-1:0] = microframe_number;
          next_rdata[FRAME_LSB +: FRAME_W] = frame_number;
        end
        OFF_MASK: begin
          next_rdata[NUM_FLAGS-1:0] = event_mask_register;
        end
        OFF_CONTROL: begin
          next_rdata[BIT_FREEZE] = controller_clock_freeze;
        end
        default: begin
          next_rdata = '0;
        end
      endcase
    end
  end

  // Read data stands for exactly the cycle after the strobe.
  always_ff @(posedge clock) begin
    if (rst) begin
      rdata <= '0;
    end else if (ce) begin
      rdata <= next_rdata;
    end
  end

endmodule // usb_bus_event_flags

// file: hw/usb_event_pkg.sv
// Shared constants for the USB device bus-event flag block.
package usb_event_pkg;

  // Register bus geometry.
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register byte offsets.
  localparam logic [7:0] OFF_STATUS = 8'h00;
  localparam logic [7:0] OFF_FRAME = 8'h04;
  localparam logic [7:0] OFF_CLEAR = 8'h08;
  localparam logic [7:0] OFF_MASK = 8'h0C;
  localparam logic [7:0] OFF_CONTROL = 8'h10;

  // Flag bit positions, shared by status, clear and mask registers.
  localparam int NUM_FLAGS = 6;
  localparam int BIT_SLEEP = 0;
  localparam int BIT_MICROFRAME = 1;
  localparam int BIT_FRAME = 2;
  localparam int BIT_RESET_END = 3;
  localparam int BIT_REVIVE = 4;
  localparam int BIT_RESUME_END = 5;

  // Frame register layout: micro-frame number low, frame number above it.
  localparam int MICRO_W = 3;
  localparam int FRAME_W = 11;
  localparam int FRAME_LSB = 3;

  // Control register layout.
  localparam int BIT_FREEZE = 0;

  // Reset values.
  localparam logic [NUM_FLAGS-1:0] FLAGS_RESET = 6'h00;
  localparam logic [NUM_FLAGS-1:0] MASK_RESET = 6'h00;
  localparam logic FREEZE_RESET = 1'b0;

  // Timing: bus idle time before sleep, and the cycle count derived from it.
  localparam int CLOCK_HZ = 20_000_000;
  localparam int SLEEP_IDLE_US = 3000;
  localparam int SLEEP_IDLE_CYCLES = SLEEP_IDLE_US * (CLOCK_HZ / 1_000_000);
  localparam int IDLE_CNT_W = 17;

  // Line activity must persist this many cycles to count as non-idle.
  localparam int REVIVE_FILTER_CYCLES = 4;
  localparam int FILTER_CNT_W = 3;

  // Bus activity tracking states.
  typedef enum logic [1:0] {
    LINK_ACTIVE,
    LINK_IDLE_COUNT,
    LINK_ASLEEP
  } link_state_e;

endpackage

// file: hw/line_activity_filter.sv
// Glitch filter that qualifies non-idle activity on the bus lines.
`timescale 1ns/100ps
module line_activity_filter
  import usb_event_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  input wire logic raw_active,
  output logic filtered_active
);

  logic [FILTER_CNT_W-1:0] run_count;

  // A short spike resets the run, so noise never reaches the revive logic.
  always_ff @(posedge clock) begin
    if (rst) begin
      run_count <= '0;
      filtered_active <= 1'b0;
    end else if (ce) begin
      if (!raw_active) begin
        run_count <= '0;
        filtered_active <= 1'b0;
      end else if (run_count == FILTER_CNT_W'(REVIVE_FILTER_CYCLES - 1)) begin
        filtered_active <= 1'b1;
      end else begin
        run_count <= run_count + 1'b1;
      end
    end
  end

endmodule // line_activity_filter

// file: verif/usb_bus_event_flags_props.sv
// Port-level checker for the USB bus-event flag block.
`timescale 1ns/100ps
module usb_bus_event_flags_props
  import usb_event_pkg::*;
#(
  parameter int SLEEP_CYCLES = SLEEP_IDLE_CYCLES
)
(
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [DATA_W-1:0] rdata,
  input wire logic irq,
  input wire logic high_speed,
  input wire logic line_idle_j,
  input wire logic line_non_idle,
  input wire logic upstream_resume_drive,
  input wire logic resume_end_det,
  input wire logic bus_reset_end_det,
  input wire logic frame_start_det,
  input wire logic [FRAME_W-1:0] frame_start_number,
  input wire logic microframe_start_det
);
  logic [NUM_FLAGS-1:0] msk;
  logic fz;
  logic [FRAME_W-1:0] fn;
  logic [MICRO_W-1:0] mf;
  logic [IDLE_CNT_W-1:0] idl;
  logic [2:0] run;
  logic asleep;
  logic act;
  logic wrc;
  logic quiet;
  logic [NUM_FLAGS-1:0] ev;
  // Qualified activity, clear-word writes and this cycle's events in flag layout.
  assign act = line_non_idle && !upstream_resume_drive;
  assign wrc = wr && ce && addr == OFF_CLEAR;
  assign quiet = !msk[BIT_SLEEP] && !msk[BIT_REVIVE];
  assign ev = {resume_end_det, 1'h0, bus_reset_end_det, frame_start_det,
    microframe_start_det && high_speed, 1'h0};
  // Shadow of mask and freeze, so event checks know what may reach the interrupt.
  always_ff @(posedge clock) begin
    if (rst) begin
      msk <= MASK_RESET;
      fz <= FREEZE_RESET;
    end else if (wr && ce) begin
      if (addr == OFF_MASK) msk <= wdata[NUM_FLAGS-1:0];
      if (addr == OFF_CONTROL) fz <= wdata[BIT_FREEZE];
    end
  end
  // Expected frame word; tokens arriving while frozen are dropped.
  always_ff @(posedge clock) begin
    if (rst) begin
      fn <= '0;
      mf <= '0;
    end else if (ce && !fz && frame_start_det) begin
      fn <= frame_start_number;
      if (high_speed) mf <= '0;
    end else if (ce && !fz && microframe_start_det && high_speed) begin
      mf <= mf + 3'h1;
    end
  end
  // Idle run length; it saturates so the sleep point is met only once per run.
  always_ff @(posedge clock) begin
    if (rst || !line_idle_j) idl <= '0;
    else if (ce && !fz && idl <= SLEEP_CYCLES) idl <= idl + 17'h1;
  end
  // Activity run, not gated by freeze since revival must work with the clock stopped.
  always_ff @(posedge clock) begin
    if (rst || !act) run <= '0;
    else if (run != 3'h7) run <= run + 3'h1;
  end
  // Asleep from the sleep point until a full activity run revives the link.
  always_ff @(posedge clock) begin
    if (rst) asleep <= 1'h0;
    else if (idl == SLEEP_CYCLES) asleep <= 1'h1;
    else if (run == 3'h3 && act) asleep <= 1'h0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  default clocking dc @(posedge clock); endclocking
  default disable iff (rst);
  read_idle_zero_a: assert property (!$past(rd) |-> rdata == '0)
    else $error("read data not zero outside a read answer");
  clear_reads_zero_a: assert property ($past(rd) && $past(addr) == OFF_CLEAR |-> rdata == '0)
    else $error("clear word did not read as zero");
  frame_word_a: assert property ($past(rd) && $past(addr) == OFF_FRAME |->
    rdata == {18'h0, $past(fn), $past(mf)})
    else $error("frame word differs from token history");
  event_irq_a: assert property ((|(ev & msk)) && ce && !fz && !wr |=> irq)
    else $error("enabled bus event did not raise the interrupt");
  sleep_irq_a: assert property (idl == SLEEP_CYCLES && msk[BIT_SLEEP] |-> irq)
    else $error("idle period elapsed without sleep interrupt");
  revive_irq_a: assert property (asleep && run == 3'h0 && act && msk[BIT_REVIVE]
    ##1 act [*3] |-> ##2 irq)
    else $error("line activity did not revive the link");
  clear_irq_a: assert property (wrc && quiet && (wdata[NUM_FLAGS-1:0] | ~msk) == 6'h3F
    && !(|(ev & msk)) |=> !irq)
    else $error("interrupt stayed high after clearing all enabled flags");
  zero_clear_a: assert property (irq && wrc && quiet && wdata[NUM_FLAGS-1:0] == '0 |=> irq)
    else $error("writing zeros to the clear word dropped the interrupt");
endmodule // usb_bus_event_flags_props

// file: verif/usb_host_model.sv
// Behavioural USB host side: tokens, bus events and line states.
`timescale 1ns/100ps
module usb_host_model
  import usb_event_pkg::*;
(
  input wire logic clock,
  output logic high_speed,
  output logic line_idle_j,
  output logic line_non_idle,
  output logic resume_end_det,
  output logic bus_reset_end_det,
  output logic frame_start_det,
  output logic [FRAME_W-1:0] frame_start_number,
  output logic microframe_start_det
);
  // Lines start neither idle nor active, as just after attach.
  initial begin
    high_speed = 1'h1;
    line_idle_j = 1'h0;
    line_non_idle = 1'h0;
    {resume_end_det, bus_reset_end_det, frame_start_det, microframe_start_det} = 4'h0;
    frame_start_number = '0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // One-cycle event: 0 resume end, 1 reset end, 2 frame token, else micro token.
  task automatic tok(input int k, input logic [FRAME_W-1:0] n);
    @(posedge clock);
    case (k)
      0: resume_end_det <= 1'h1;
      1: bus_reset_end_det <= 1'h1;
      2: {frame_start_det, frame_start_number} <= {1'h1, n};
      default: microframe_start_det <= 1'h1;
    endcase
    @(posedge clock);
    {resume_end_det, bus_reset_end_det, frame_start_det, microframe_start_det} <= 4'h0;
    frame_start_number <= ~n; // The number means nothing off the token, so it is scrambled.
  endtask
  // Hold the J state for n cycles.
  task automatic idle(input int n);
    @(posedge clock);
    line_idle_j <= 1'h1;
    repeat (n) @(posedge clock);
    line_idle_j <= 1'h0;
  endtask
  // Drive non-idle line activity for n cycles.
  task automatic wake(input int n);
    @(posedge clock);
    line_non_idle <= 1'h1;
    repeat (n) @(posedge clock);
    line_non_idle <= 1'h0;
  endtask
endmodule // usb_host_model

// file: verif/usb_bus_event_flags_tb.sv
// Self-checking bench for the USB bus-event flag block.
`timescale 1ns/100ps
module usb_bus_event_flags_tb
  import usb_event_pkg::*;
;
  localparam int SLP = 20;
  logic clock, rst, ce, wr, rd, irq, rd_q, high_speed, line_idle_j, line_non_idle;
  logic upstream_resume_drive, resume_end_det, bus_reset_end_det;
  logic frame_start_det, microframe_start_det;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata, rdata;
  logic [FRAME_W-1:0] frame_start_number;
  logic [31:0] rng;
  logic [DATA_W-1:0] expq[$];
  int evb[4];
  int num_errors = 0;
  int n_tests = 0;
  usb_bus_event_flags #(.SLEEP_CYCLES(SLP)) usb_bus_event_flags_inst (.*);
  usb_host_model usb_host_model_inst (.*);
  // Free-running 20 MHz clock.
  initial begin
    clock = 1'h0;
    forever #25 clock = ~clock;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Read data stand only in the cycle after the strobe, so they are taken mid-cycle there.
  always @(posedge clock) rd_q <= rd;
  always @(negedge clock) begin
    if (rd_q) chk("rdata", rdata, expq.pop_front());
  end
  task automatic wreg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clock);
    {wr, addr, wdata} <= {1'h1, a, d};
    @(posedge clock);
    wr <= 1'h0;
  endtask
  task automatic rreg(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    @(posedge clock);
    {rd, addr} <= {1'h1, a};
    expq.push_back(e);
    @(posedge clock);
    rd <= 1'h0;
  endtask
  // The interrupt is registered, so it is looked at mid-cycle, once the edge has landed.
  // The task ends on a rising edge, so inputs set after it still change on the edge.
  task automatic ckirq(input logic e);
    @(negedge clock);
    chk("irq", {31'h0, irq}, {31'h0, e});
    @(posedge clock);
  endtask
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic test_done;
    $display("Checks %0d, mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Main sequence.
  initial begin
    {rst, ce, wr, rd, upstream_resume_drive} = 5'h18;
    {addr, wdata} = '0;
    rng = 32'h69C0D6F0;
    evb = '{BIT_RESUME_END, BIT_RESET_END, BIT_FRAME, BIT_MICROFRAME};
    repeat (8) @(posedge clock);
    rst <= 1'h0;
    for (int a = 0; a < 24; a += 4) rreg(a[7:0], '0);
    wreg(8'h14, '1);
    wreg(OFF_STATUS, '1);
    rreg(8'h14, '0);
    rreg(OFF_STATUS, '0);
    wreg(OFF_MASK, '1);
    rreg(OFF_MASK, 32'h3F);
    wreg(OFF_MASK, 32'h2E);
    for (int k = 0; k < 4; k++) begin
      usb_host_model_inst.tok(k, '0);
      ckirq(1'h1);
      rreg(OFF_STATUS, 32'h1 << evb[k]);
      wreg(OFF_CLEAR, 32'h0);
      rreg(OFF_STATUS, 32'h1 << evb[k]);
      wreg(OFF_CLEAR, 32'h1 << evb[k]);
      rreg(OFF_STATUS, 32'h0);
      ckirq(1'h0);
    end
    // Nine micro tokens wrap the three-bit count to one.
    repeat (3) begin
      rng = lfsr(rng);
      usb_host_model_inst.tok(2, rng[10:0]);
      rreg(OFF_FRAME, {18'h0, rng[10:0], 3'h0});
      repeat (9) usb_host_model_inst.tok(3, '0);
      rreg(OFF_FRAME, {18'h0, rng[10:0], 3'h1});
    end
    wreg(OFF_CLEAR, 32'h3F);
    usb_host_model_inst.high_speed <= 1'h0;
    usb_host_model_inst.tok(3, '0);
    rreg(OFF_STATUS, 32'h0);
    rreg(OFF_FRAME, {18'h0, rng[10:0], 3'h1});
    wreg(OFF_MASK, 32'h0);
    usb_host_model_inst.tok(0, '0);
    ckirq(1'h0);
    wreg(OFF_CONTROL, 32'h1);
    rreg(OFF_CONTROL, 32'h1);
    usb_host_model_inst.tok(1, '0);
    rreg(OFF_STATUS, 32'h20);
    wreg(OFF_CONTROL, 32'h0);
    wreg(OFF_CLEAR, 32'h3F);
    wreg(OFF_MASK, 32'h11);
    usb_host_model_inst.idle(SLP + 2);
    rreg(OFF_STATUS, 32'h1);
    ckirq(1'h1);
    upstream_resume_drive <= 1'h1;
    usb_host_model_inst.wake(8);
    upstream_resume_drive <= 1'h0;
    rreg(OFF_STATUS, 32'h1);
    usb_host_model_inst.idle(SLP + 2);
    wreg(OFF_CONTROL, 32'h1);
    usb_host_model_inst.wake(6);
    rreg(OFF_STATUS, 32'h10);
    wreg(OFF_CLEAR, 32'h10);
    rreg(OFF_STATUS, 32'h10);
    wreg(OFF_CONTROL, 32'h0);
    usb_host_model_inst.idle(SLP + 2);
    rreg(OFF_STATUS, 32'h1);
    usb_host_model_inst.wake(6);
    wreg(OFF_CLEAR, 32'h10);
    rreg(OFF_STATUS, 32'h0);
    ckirq(1'h0);
    // With the clock enable low, a token must leave every flag untouched.
    ce <= 1'h0;
    usb_host_model_inst.tok(1, '0);
    ce <= 1'h1;
    rreg(OFF_STATUS, 32'h0);
    repeat (2) @(posedge clock);
    test_done();
  end
  // The whole run needs well under a thousand cycles.
  initial begin
    repeat (5000) @(posedge clock);
    num_errors++;
    test_done();
  end
endmodule // usb_bus_event_flags_tb
bind usb_bus_event_flags usb_bus_event_flags_props #(.SLEEP_CYCLES(SLEEP_CYCLES))
  usb_bus_event_flags_props_inst (.*);
